// [common/kpd_consts.svh]
`ifndef KPD_CONSTS_SVH
`define KPD_CONSTS_SVH

// Register offsets on the internal register port
`define KPD_ADDR_IRQ_CLEAR   8'h08
`define KPD_ADDR_SLOT_FIRST  8'h0b
`define KPD_ADDR_SLOT_SECOND 8'h0c
`define KPD_ADDR_SLOT_THIRD  8'h0d
`define KPD_ADDR_SLOT_FOURTH 8'h0e
`define KPD_ADDR_EVENT_QUEUE 8'h10

// Bit positions
`define KPD_BIT_SCAN_CLEAR   0
`define KPD_BIT_EVT_FLUSH    1
`define KPD_BIT_FLAG         7

// Values
`define KPD_CODE_EMPTY       8'h7f
`define KPD_READ_UNMAPPED    8'h00
`define KPD_ROW_RESET        3'h7
`define KPD_COL_RESET        4'hf

// Sizes
`define KPD_SLOT_COUNT       4
`define KPD_EVT_DEPTH        15

`endif

// [common/kpd_pkg.sv]
package kpd_pkg;

    // Row and column of one key
    typedef struct packed {
        logic [2:0] key_row_index;
        logic [3:0] key_column_index;
    } kpd_key_t;

    // One byte as read by the host: flag bit over key position
    typedef struct packed {
        logic     flag;
        kpd_key_t key;
    } kpd_code_t;

    // Result of one keyboard scan
    typedef struct packed {
        kpd_key_t [3:0] keys;
        logic     [2:0] count;
        logic           too_many;
    } kpd_scan_t;

endpackage : kpd_pkg

// [hdl/kpd_event_fifo.sv]
`timescale 1ns/1ns
`include "kpd_consts.svh"

module kpd_event_fifo #(
    parameter int DEPTH = `KPD_EVT_DEPTH,
    parameter int PTR_W = 4
) (
    input  wire logic             clk_sys,   // System clock
    input  wire logic             rst_n,     // Synchronised reset
    input  wire logic             push,      // Store one event
    input  wire kpd_pkg::kpd_code_t push_data, // Event to store
    input  wire logic             pop,       // Remove the oldest event
    input  wire logic             flush,     // Drop everything
    output kpd_pkg::kpd_code_t    head,      // Oldest event
    output logic                  empty,     // No event held
    output logic                  overflow   // Push refused, queue full
);

    kpd_pkg::kpd_code_t mem [DEPTH];
    logic [PTR_W-1:0]   wr_ptr_reg;
    logic [PTR_W-1:0]   rd_ptr_reg;
    logic [PTR_W:0]     count_reg;
    logic               full;
    logic               do_push;
    logic               do_pop;

    function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
        next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : next_ptr

    assign full     = (count_reg == (PTR_W + 1)'(DEPTH));
    assign empty    = (count_reg == '0);
    assign do_pop   = pop && !empty;
    assign do_push  = push && (!full || do_pop);
    assign overflow = push && full && !do_pop;
    assign head     = mem[rd_ptr_reg];

    //////////////////////////////////////////////////////////////////////
    // Storage, newest written behind the rest
    always_ff @(posedge clk_sys) begin
        if (do_push && !flush) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= next_ptr(wr_ptr_reg);
            end
            if (do_pop) begin
                rd_ptr_reg <= next_ptr(rd_ptr_reg);
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : kpd_event_fifo

// [hdl/kpd_readout.sv]
`timescale 1ns/1ns
`include "kpd_consts.svh"

module kpd_readout #(
    parameter int EVT_DEPTH = `KPD_EVT_DEPTH
) (
    input  wire logic               clk_sys,              // System clock, 10 MHz
    input  wire logic               rstn,                 // Asynchronous reset, active low
    input  wire logic               ptr_load,             // Load register pointer
    input  wire logic [7:0]         ptr_value,            // New register pointer
    input  wire logic               rd_stb,               // Read one byte at pointer
    input  wire logic               wr_stb,               // Write one byte at pointer
    input  wire logic [7:0]         wr_data,              // Byte written
    output logic [7:0]              rd_data,              // Byte read
    input  wire logic               scan_update,          // Scan result changed
    input  wire kpd_pkg::kpd_scan_t scan_result,          // Keys held after the scan
    input  wire logic               evt_valid,            // New press or release
    input  wire kpd_pkg::kpd_code_t evt_code,             // Event, flag set for release
    output logic                    scan_interrupt_flag,  // Scan result pending
    output logic                    key_event_interrupt,  // Events queued
    output logic                    event_lost_interrupt, // Queue overflowed
    output logic                    key_lost_interrupt    // Key code lost
);

    logic                rst_meta_reg;
    logic                rst_sync_reg;
    logic                rst_n;
    logic [7:0]          ptr_reg;
    logic [7:0]          rd_data_reg;
    kpd_pkg::kpd_code_t  slot_reg [`KPD_SLOT_COUNT];
    logic [3:0]          slot_read_reg;
    logic [3:0]          slot_read_next;
    logic                scan_flag_reg;
    logic                key_lost_reg;
    logic                evt_lost_reg;
    logic                evt_irq_reg;
    logic                rd_slot;
    logic                rd_queue;
    logic                clr_scan;
    logic                flush;
    logic                all_read;
    kpd_pkg::kpd_code_t  fifo_head;
    logic                fifo_empty;
    logic                fifo_overflow;
    logic                pop;

    //////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    //////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic is_slot(input logic [7:0] a);
        is_slot = (a >= `KPD_ADDR_SLOT_FIRST) && (a <= `KPD_ADDR_SLOT_FOURTH);
    endfunction : is_slot

    function automatic logic [1:0] slot_index(input logic [7:0] a);
        logic [7:0] d;
        d          = a - `KPD_ADDR_SLOT_FIRST;
        slot_index = d[1:0];
    endfunction : slot_index

    // Slot n: key n if present, else the empty code; flag tells a further key
    function automatic kpd_pkg::kpd_code_t build_slot(input kpd_pkg::kpd_scan_t s, input int n);
        kpd_pkg::kpd_code_t c;
        c = `KPD_CODE_EMPTY;
        if (32'(s.count) > n) begin
            c.key = s.keys[n];
        end
        if (n == `KPD_SLOT_COUNT - 1) begin
            c.flag = s.too_many;
        end else begin
            c.flag = (32'(s.count) > n + 1);
        end
        build_slot = c;
    endfunction : build_slot

    assign rd_slot  = rd_stb && is_slot(ptr_reg);
    assign rd_queue = rd_stb && (ptr_reg == `KPD_ADDR_EVENT_QUEUE);
    assign clr_scan = wr_stb && (ptr_reg == `KPD_ADDR_IRQ_CLEAR) && wr_data[`KPD_BIT_SCAN_CLEAR];
    assign flush    = wr_stb && (ptr_reg == `KPD_ADDR_IRQ_CLEAR) && wr_data[`KPD_BIT_EVT_FLUSH];
    assign pop      = rd_queue && !fifo_empty;

    //////////////////////////////////////////////////////////////////////
    // Register pointer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= 8'h00;
        end else if (ptr_load) begin
            ptr_reg <= ptr_value;
        end else if ((rd_stb || wr_stb) && (ptr_reg != `KPD_ADDR_EVENT_QUEUE)) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Key slots
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `KPD_SLOT_COUNT; i++) begin
                slot_reg[i] <= {1'b0, `KPD_ROW_RESET, `KPD_COL_RESET};
            end
        end else if (scan_update) begin
            for (int i = 0; i < `KPD_SLOT_COUNT; i++) begin
                slot_reg[i] <= build_slot(scan_result, i);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= `KPD_READ_UNMAPPED;
        end else if (rd_stb) begin
            if (rd_slot) begin
                rd_data_reg <= slot_reg[slot_index(ptr_reg)];
            end else if (ptr_reg == `KPD_ADDR_EVENT_QUEUE) begin
                rd_data_reg <= fifo_empty ? `KPD_CODE_EMPTY : fifo_head;
            end else begin
                rd_data_reg <= `KPD_READ_UNMAPPED;
            end
        end
    end

    assign rd_data = rd_data_reg;

    //////////////////////////////////////////////////////////////////////
    // Slot read tracking and scan flag
    always_comb begin
        slot_read_next = slot_read_reg;
        if (rd_slot) begin
            slot_read_next[slot_index(ptr_reg)] = 1'b1;
        end
    end

    assign all_read = rd_slot && (slot_read_next == 4'hf);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slot_read_reg <= 4'h0;
        end else if (scan_update || all_read || clr_scan) begin
            slot_read_reg <= 4'h0;
        end else begin
            slot_read_reg <= slot_read_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scan_flag_reg <= 1'b0;
        end else if (scan_update) begin
            scan_flag_reg <= 1'b1;
        end else if (all_read || clr_scan) begin
            scan_flag_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Key lost flag
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_lost_reg <= 1'b0;
        end else if ((scan_update && scan_flag_reg) || (scan_update && scan_result.too_many)) begin
            key_lost_reg <= 1'b1;
        end else if (clr_scan) begin
            key_lost_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Event queue and its flags
    kpd_event_fifo #(
        .DEPTH     (EVT_DEPTH),
        .PTR_W     (4)
    ) u_event_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .push      (evt_valid),
        .push_data (evt_code),
        .pop       (pop),
        .flush     (flush),
        .head      (fifo_head),
        .empty     (fifo_empty),
        .overflow  (fifo_overflow)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_lost_reg <= 1'b0;
        end else if (fifo_overflow) begin
            evt_lost_reg <= 1'b1;
        end else if (flush) begin
            evt_lost_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_irq_reg <= 1'b0;
        end else begin
            evt_irq_reg <= !fifo_empty;
        end
    end

    assign scan_interrupt_flag  = scan_flag_reg;
    assign key_event_interrupt  = evt_irq_reg;
    assign event_lost_interrupt = evt_lost_reg;
    assign key_lost_interrupt   = key_lost_reg;

    //////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_slot_empty_code: assert property (
        scan_update && (scan_result.count == 3'h0) |=> (slot_reg[0] == `KPD_CODE_EMPTY))
        else $error("first slot not empty code without keys");

    a_slot_order_keys: assert property (
        scan_update && (scan_result.count >= 3'h2)
        |=> (slot_reg[0].key == $past(scan_result.keys[0])) && (slot_reg[1].key == $past(scan_result.keys[1])))
        else $error("slot keys out of detection order");

    a_slot_chain_flag: assert property (
        scan_update |=> (slot_reg[0].flag == ($past(scan_result.count) > 3'h1))
                     && (slot_reg[2].flag == ($past(scan_result.count) > 3'h3)))
        else $error("more keys flag wrong");

    a_fourth_overflow: assert property (
        scan_update |=> (slot_reg[3].flag == $past(scan_result.too_many)))
        else $error("fourth slot flag does not follow overflow");

    a_all_read_clear: assert property (
        rd_slot && (slot_read_next == 4'hf) && !scan_update |=> !scan_flag_reg)
        else $error("scan flag kept after all slots read");

    a_queue_empty_read: assert property (
        rd_queue && fifo_empty |=> (rd_data == `KPD_CODE_EMPTY))
        else $error("empty queue read not 0x7f");

    a_queue_no_incr: assert property (
        rd_queue && !ptr_load ##1 rd_queue && !ptr_load |=> (ptr_reg == `KPD_ADDR_EVENT_QUEUE))
        else $error("pointer moved on queue read");

    a_queue_pop_head: assert property (
        rd_queue && !fifo_empty |=> (rd_data == $past(fifo_head)))
        else $error("queue read not oldest entry");

    a_evt_irq_level: assert property (
        (evt_valid && !flush |-> ##2 evt_irq_reg)
        and (rd_queue && fifo_empty && !evt_valid |=> !evt_irq_reg))
        else $error("event interrupt does not follow queue");

    a_evt_lost_set: assert property (
        fifo_overflow |=> evt_lost_reg ##1 (evt_lost_reg || $past(flush)))
        else $error("event lost not raised on overflow");

    a_key_lost_set: assert property (
        scan_update && (scan_flag_reg || scan_result.too_many) |=> key_lost_reg)
        else $error("key lost not raised");

    a_flush_clears: assert property (
        flush && !evt_valid |=> fifo_empty && !evt_lost_reg ##1 !evt_irq_reg || $past(evt_valid))
        else $error("flush did not empty queue");

    a_scan_flag_set: assert property (
        scan_update |=> scan_flag_reg)
        else $error("scan flag not set by new scan");

    a_clear_bit_scan: assert property (
        clr_scan && !scan_update |=> !scan_flag_reg && !key_lost_reg)
        else $error("clear bit left scan flags set");

    a_evt_push_held: assert property (
        evt_valid && !flush |=> !fifo_empty)
        else $error("pushed event not held in queue");

endmodule : kpd_readout

// [tb/kpd_host_model.sv]
`timescale 1ns/1ns

module kpd_host_model (
    input  wire logic       clk_sys,   // System clock
    input  wire logic [7:0] rd_data,   // Byte read from the device
    output logic            ptr_load,  // Load register pointer
    output logic [7:0]      ptr_value, // New pointer value
    output logic            rd_stb,    // Read strobe, one byte per edge
    output logic            wr_stb,    // Write strobe
    output logic [7:0]      wr_data    // Byte to write
);
    logic [7:0] q [0:15]; // Bytes of the last read burst

    initial begin
        ptr_load  = 1'b0;
        ptr_value = 8'h00;
        rd_stb    = 1'b0;
        wr_stb    = 1'b0;
        wr_data   = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer load, then reads with the strobe held over n edges
    task automatic read_burst(input logic [7:0] addr, input int n);
        int i;
        @(posedge clk_sys);
        ptr_load  <= 1'b1;
        ptr_value <= addr;
        @(posedge clk_sys);
        ptr_load  <= 1'b0;
        ptr_value <= ~addr;
        rd_stb    <= 1'b1;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if (i == n - 1) begin
                rd_stb <= 1'b0;
            end
            #1;
            q[i] = rd_data;
        end
    endtask : read_burst

    // Released lines show the inverse so a stale value is never taken
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] d);
        @(posedge clk_sys);
        ptr_load  <= 1'b1;
        ptr_value <= addr;
        @(posedge clk_sys);
        ptr_load  <= 1'b0;
        ptr_value <= ~addr;
        wr_stb    <= 1'b1;
        wr_data   <= d;
        @(posedge clk_sys);
        wr_stb    <= 1'b0;
        wr_data   <= ~d;
    endtask : write_byte
endmodule : kpd_host_model

// [tb/kpd_readout_tb_top.sv]
`timescale 1ns/1ns
`include "kpd_consts.svh"

module kpd_readout_tb_top;
    logic               clk_sys;
    logic               rstn;
    logic               scan_update;
    kpd_pkg::kpd_scan_t scan_result;
    logic               evt_valid;
    kpd_pkg::kpd_code_t evt_code;
    logic               ptr_load;
    logic [7:0]         ptr_value;
    logic               rd_stb;
    logic               wr_stb;
    logic [7:0]         wr_data;
    logic [7:0]         rd_data;
    logic               scan_irq;
    logic               evt_irq;
    logic               lost_irq;
    logic               key_lost;
    int                 num_errors;
    int                 checks_done;

    localparam kpd_pkg::kpd_key_t KA = {3'h2, 4'hc};
    localparam kpd_pkg::kpd_key_t KB = {3'h5, 4'he};
    localparam kpd_pkg::kpd_key_t KC = {3'h7, 4'h0};
    localparam kpd_pkg::kpd_key_t KD = {3'h3, 4'hd};

    kpd_readout i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .ptr_load(ptr_load), .ptr_value(ptr_value),
        .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data),
        .scan_update(scan_update), .scan_result(scan_result), .evt_valid(evt_valid),
        .evt_code(evt_code), .scan_interrupt_flag(scan_irq), .key_event_interrupt(evt_irq),
        .event_lost_interrupt(lost_irq), .key_lost_interrupt(key_lost)
    );

    kpd_host_model i_host (
        .clk_sys(clk_sys), .rd_data(rd_data), .ptr_load(ptr_load), .ptr_value(ptr_value),
        .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Event pattern: alternating press and release, columns 0 to 14
    function automatic logic [7:0] ev(input int i);
        return {i[0], i[2:0], 4'(i % 15)};
    endfunction : ev

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////
    task automatic do_scan(input kpd_pkg::kpd_key_t k3, k2, k1, k0, input logic [2:0] cnt, input logic tm);
        @(posedge clk_sys);
        scan_update <= 1'b1;
        scan_result <= {k3, k2, k1, k0, cnt, tm};
        @(posedge clk_sys);
        scan_update <= 1'b0;
        scan_result <= ~{k3, k2, k1, k0, cnt, tm};
        settle();
    endtask : do_scan

    task automatic push_evts(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys);
            evt_valid <= 1'b1;
            evt_code  <= ev(i);
        end
        @(posedge clk_sys);
        evt_valid <= 1'b0;
        evt_code  <= ~ev(n - 1);
        settle();
    endtask : push_evts

    task automatic check_slots(input logic [7:0] e0, e1, e2, e3);
        i_host.read_burst(`KPD_ADDR_SLOT_FIRST, 4);
        check("slot first", e0, i_host.q[0]);
        check("slot second", e1, i_host.q[1]);
        check("slot third", e2, i_host.q[2]);
        check("slot fourth", e3, i_host.q[3]);
    endtask : check_slots

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        check_slots(`KPD_CODE_EMPTY, `KPD_CODE_EMPTY, `KPD_CODE_EMPTY, `KPD_CODE_EMPTY);
        check("reset row col", {1'b0, `KPD_ROW_RESET, `KPD_COL_RESET}, i_host.q[0]);
        i_host.read_burst(`KPD_ADDR_EVENT_QUEUE, 1);
        check("empty queue", `KPD_CODE_EMPTY, i_host.q[0]);
        i_host.read_burst(8'h20, 1);
        check("unmapped", `KPD_READ_UNMAPPED, i_host.q[0]);
        check("irqs idle", 8'h00, {4'h0, scan_irq, evt_irq, lost_irq, key_lost});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_slots;
        do_scan(KD, KC, KB, KA, 3'h3, 1'b0);
        check("scan flag set", 8'h01, {7'h00, scan_irq});
        check("no key lost", 8'h00, {7'h00, key_lost});
        check_slots({1'b1, KA}, {1'b1, KB}, {1'b0, KC}, `KPD_CODE_EMPTY);
        settle();
        check("scan flag cleared", 8'h00, {7'h00, scan_irq});
        do_scan(KD, KC, KB, KA, 3'h4, 1'b1);
        check("key lost many", 8'h01, {7'h00, key_lost});
        check("scan flag pending", 8'h01, {7'h00, scan_irq});
        i_host.write_byte(`KPD_ADDR_IRQ_CLEAR, 8'h01);
        settle();
        check("clear bit", 8'h00, {6'h00, scan_irq, key_lost});
        check_slots({1'b1, KA}, {1'b1, KB}, {1'b1, KC}, {1'b1, KD});
        do_scan(KD, KC, KB, KA, 3'h1, 1'b0);
        do_scan(KD, KC, KA, KB, 3'h2, 1'b0);
        check("key lost uncleared", 8'h01, {7'h00, key_lost});
        check_slots({1'b1, KB}, {1'b0, KA}, `KPD_CODE_EMPTY, `KPD_CODE_EMPTY);
        i_host.write_byte(`KPD_ADDR_IRQ_CLEAR, 8'h01);
        $display("test_slots done");
    endtask : test_slots

    task automatic test_events;
        int i;
        push_evts(3);
        check("event irq set", 8'h01, {7'h00, evt_irq});
        i_host.read_burst(`KPD_ADDR_EVENT_QUEUE, 4);
        for (i = 0; i < 3; i++) begin
            check("event entry", ev(i), i_host.q[i]);
        end
        check("queue drained", `KPD_CODE_EMPTY, i_host.q[3]);
        settle();
        check("event irq clear", 8'h00, {7'h00, evt_irq});
        $display("test_events done");
    endtask : test_events

    task automatic test_overflow;
        int i;
        push_evts(16);
        check("event lost", 8'h01, {7'h00, lost_irq});
        i_host.read_burst(`KPD_ADDR_EVENT_QUEUE, 16);
        for (i = 0; i < 15; i++) begin
            check("full queue entry", ev(i), i_host.q[i]);
        end
        check("overflow dropped", `KPD_CODE_EMPTY, i_host.q[15]);
        push_evts(2);
        i_host.read_burst(`KPD_ADDR_EVENT_QUEUE, 1);
        check("read before flush", ev(0), i_host.q[0]);
        i_host.write_byte(`KPD_ADDR_IRQ_CLEAR, 8'h02);
        settle();
        check("flush irqs", 8'h00, {6'h00, evt_irq, lost_irq});
        i_host.read_burst(`KPD_ADDR_EVENT_QUEUE, 1);
        check("flushed queue", `KPD_CODE_EMPTY, i_host.q[0]);
        $display("test_overflow done");
    endtask : test_overflow

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors  = 0;
        checks_done = 0;
        rstn        = 1'b0;
        scan_update = 1'b0;
        scan_result = '0;
        evt_valid   = 1'b0;
        evt_code    = '0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        test_reset();
        test_slots();
        test_events();
        test_overflow();
        tally_and_finish();
    end

    // Tests take well under a thousand cycles
    initial begin
        #(100 * 5000);
        $display("watchdog expired");
        num_errors++;
        tally_and_finish();
    end
endmodule : kpd_readout_tb_top
